/* inc/port_ans_cn_defs.svh */
`ifndef PORT_ANS_CN_DEFS_SVH
`define PORT_ANS_CN_DEFS_SVH

// register byte offsets on the axi4-lite bus
`define OFS_ANS_A 8'h00
`define OFS_ANS_B 8'h04
`define OFS_ANS_C 8'h08
`define OFS_DIR_A 8'h0C
`define OFS_DIR_B 8'h10
`define OFS_DIR_C 8'h14
`define OFS_LAT_A 8'h18
`define OFS_LAT_B 8'h1C
`define OFS_LAT_C 8'h20
`define OFS_PORT_A 8'h24
`define OFS_PORT_B 8'h28
`define OFS_PORT_C 8'h2C
`define OFS_CN_EN_LO 8'h30
`define OFS_CN_EN_HI 8'h34
`define OFS_PU_LO 8'h38
`define OFS_PU_HI 8'h3C
`define OFS_PD_LO 8'h40
`define OFS_PD_HI 8'h44
`define OFS_CN_STAT 8'h48

// implemented analog select bits, full pin-count variant
`define ANS_A_MASK 16'h000F
`define ANS_B_MASK 16'hF01F
`define ANS_B_BIT3 16'h0008
`define ANS_C_MASK 16'h0007

// reset values
`define ANS_RESET 16'hFFFF
`define DIR_RESET 16'hFFFF
`define LAT_RESET 16'h0000
`define CN_RESET 23'h00_0000

// change-notification input split over lo/hi registers
`define CN_LO_BITS 16
`define CN_HI_BITS 7
`define CN_STAT_FLAG_BIT 0

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* inc/port_ans_cn_pkg.sv */
package port_ans_cn_pkg;

    // write channel sequencer, one-hot
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

    // read channel sequencer, one-hot
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_e;

    // master to slave axi4-lite signals
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_s;

    // slave to master axi4-lite signals
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

    // three 16-bit ports, index 0 = a, 1 = b, 2 = c
    typedef logic [2:0][15:0] port3_t;

    // whole module state
    typedef struct packed {
        port3_t ans;
        port3_t dir;
        port3_t lat;
        port3_t pin_out;
        port3_t pin_oe;
        logic [22:0] cn_en;
        logic [22:0] pu;
        logic [22:0] pd;
        logic [22:0] pu_out;
        logic [22:0] pd_out;
        logic [22:0] snap;
        logic cn_flag;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        wr_state_e wr_st;
        rd_state_e rd_st;
        axi_rsp_s rsp;
    } state_s;

endpackage

/* rtl/port_ans_cn.sv */
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "port_ans_cn_defs.svh"

// Function
// - analog pin set to output drives latch level
// - analog pins read zero in port value
// - analog select one disables digital input buffer
// - port a select bits 3..0, reset one
// - port b bits 15..12, 4..0, reset one
// - port b bit 3 absent on 20-pin
// - port c bits 2..0, absent on 20/28-pin
// - non-analog bits unimplemented, one register per port
// - change of state raises interrupt request
// - detection survives stopped clock in sleep
// - 23 change inputs, each individually selectable
// - two enable registers gate change interrupts
// - two pull-up registers, one bit per input
// - two pull-down registers, one bit per input
// - direction one is input, reset to input
module port_ans_cn
    import port_ans_cn_pkg::*;
#(
    parameter int PIN_COUNT = 44 // 20, 28, 44 or 48 pin variant
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire axi_req_s axi_req,
    output axi_rsp_s axi_rsp,
    input wire port3_t pin_in,
    output port3_t pin_out,
    output port3_t pin_oe,
    input wire logic [22:0] change_in,
    input wire logic sleep,
    output logic [22:0] pullup_en,
    output logic [22:0] pulldown_en,
    output logic change_irq,
    output port3_t digital_in_off
);

    // implemented analog select bits for this variant
    localparam logic [15:0] ANS_B_IMPL = (PIN_COUNT == 20) ?
        (`ANS_B_MASK & ~`ANS_B_BIT3) : `ANS_B_MASK;
    localparam logic [15:0] ANS_C_IMPL = (PIN_COUNT <= 28) ?
        16'h0000 : `ANS_C_MASK;
    localparam port3_t ANS_IMPL = {ANS_C_IMPL, ANS_B_IMPL, `ANS_A_MASK};

    state_s s_r; // registered state
    state_s s_nxt; // next state

    logic [15:0] wr_val; // write data merged with byte strobes
    logic [31:0] rd_val; // read mux result
    logic rd_hit; // read address decoded
    logic wr_hit; // write address decoded
    logic [22:0] cn_diff; // enabled pins differing from snapshot
    port3_t pin_val; // port value register contents

    // merge 16-bit register with low two byte lanes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0])
        begin
            r[7:0] = d[7:0];
        end
        if (strb[1])
        begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // true when the address names a mapped register
    function automatic logic addr_mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= `OFS_CN_STAT);
    endfunction

    // port value: digital buffer off reads as low level
    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            pin_val[p] = pin_in[p] & ~(s_r.ans[p] & ANS_IMPL[p]);
        end
    end

    // change detect: live pins against recorded level, no clock on this path
    assign cn_diff = (change_in ^ s_r.snap) & s_r.cn_en;

    // read decode
    always_comb
    begin
        rd_hit = addr_mapped(axi_req.araddr);
        rd_val = 32'h0000_0000;
        case (axi_req.araddr)
            `OFS_ANS_A: rd_val = {16'h0000, s_r.ans[0]};
            `OFS_ANS_B: rd_val = {16'h0000, s_r.ans[1]};
            `OFS_ANS_C: rd_val = {16'h0000, s_r.ans[2]};
            `OFS_DIR_A: rd_val = {16'h0000, s_r.dir[0]};
            `OFS_DIR_B: rd_val = {16'h0000, s_r.dir[1]};
            `OFS_DIR_C: rd_val = {16'h0000, s_r.dir[2]};
            `OFS_LAT_A: rd_val = {16'h0000, s_r.lat[0]};
            `OFS_LAT_B: rd_val = {16'h0000, s_r.lat[1]};
            `OFS_LAT_C: rd_val = {16'h0000, s_r.lat[2]};
            `OFS_PORT_A: rd_val = {16'h0000, pin_val[0]};
            `OFS_PORT_B: rd_val = {16'h0000, pin_val[1]};
            `OFS_PORT_C: rd_val = {16'h0000, pin_val[2]};
            `OFS_CN_EN_LO: rd_val = {16'h0000, s_r.cn_en[15:0]};
            `OFS_CN_EN_HI: rd_val = {25'h000_0000, s_r.cn_en[22:16]};
            `OFS_PU_LO: rd_val = {16'h0000, s_r.pu[15:0]};
            `OFS_PU_HI: rd_val = {25'h000_0000, s_r.pu[22:16]};
            `OFS_PD_LO: rd_val = {16'h0000, s_r.pd[15:0]};
            `OFS_PD_HI: rd_val = {25'h000_0000, s_r.pd[22:16]};
            `OFS_CN_STAT: rd_val = {31'h0000_0000, s_r.cn_flag};
            default: rd_val = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    // next-state logic for registers, pins and both bus channels
    always_comb
    begin
        s_nxt = s_r;
        wr_hit = addr_mapped(s_r.awaddr);
        wr_val = merge16(16'h0000, s_r.wdata, s_r.wstrb);

        // write address and data may arrive in either order
        if (axi_req.awvalid && s_r.rsp.awready)
        begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_r.rsp.wready)
        begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = axi_req.wdata;
            s_nxt.wstrb = axi_req.wstrb;
        end

        // detection: snapshot tracks pins while awake
        if (!sleep)
        begin
            s_nxt.snap = change_in;
        end
        // during sleep the snapshot holds, so a change made while the
        // clock was stopped still mismatches once it runs again
        if (|cn_diff)
        begin
            s_nxt.cn_flag = 1'b1;
        end

        case (s_r.wr_st)
            WR_IDLE:
            begin
                if (s_r.aw_got && s_r.w_got)
                begin
                    // perform the write, then answer
                    case (s_r.awaddr)
                        `OFS_ANS_A: s_nxt.ans[0] = merge16(s_r.ans[0], s_r.wdata, s_r.wstrb) & ANS_IMPL[0];
                        `OFS_ANS_B: s_nxt.ans[1] = merge16(s_r.ans[1], s_r.wdata, s_r.wstrb) & ANS_IMPL[1];
                        `OFS_ANS_C: s_nxt.ans[2] = merge16(s_r.ans[2], s_r.wdata, s_r.wstrb) & ANS_IMPL[2];
                        `OFS_DIR_A: s_nxt.dir[0] = merge16(s_r.dir[0], s_r.wdata, s_r.wstrb);
                        `OFS_DIR_B: s_nxt.dir[1] = merge16(s_r.dir[1], s_r.wdata, s_r.wstrb);
                        `OFS_DIR_C: s_nxt.dir[2] = merge16(s_r.dir[2], s_r.wdata, s_r.wstrb);
                        // writes to the port value register land in the latch
                        `OFS_LAT_A, `OFS_PORT_A: s_nxt.lat[0] = merge16(s_r.lat[0], s_r.wdata, s_r.wstrb);
                        `OFS_LAT_B, `OFS_PORT_B: s_nxt.lat[1] = merge16(s_r.lat[1], s_r.wdata, s_r.wstrb);
                        `OFS_LAT_C, `OFS_PORT_C: s_nxt.lat[2] = merge16(s_r.lat[2], s_r.wdata, s_r.wstrb);
                        `OFS_CN_EN_LO: s_nxt.cn_en[15:0] = merge16(s_r.cn_en[15:0], s_r.wdata, s_r.wstrb);
                        `OFS_CN_EN_HI: s_nxt.cn_en[22:16] = wr_val[6:0] | (s_r.cn_en[22:16] & {7{~s_r.wstrb[0]}});
                        `OFS_PU_LO: s_nxt.pu[15:0] = merge16(s_r.pu[15:0], s_r.wdata, s_r.wstrb);
                        `OFS_PU_HI: s_nxt.pu[22:16] = wr_val[6:0] | (s_r.pu[22:16] & {7{~s_r.wstrb[0]}});
                        `OFS_PD_LO: s_nxt.pd[15:0] = merge16(s_r.pd[15:0], s_r.wdata, s_r.wstrb);
                        `OFS_PD_HI: s_nxt.pd[22:16] = wr_val[6:0] | (s_r.pd[22:16] & {7{~s_r.wstrb[0]}});
                        `OFS_CN_STAT:
                        begin
                            // write one clears; a change this cycle wins
                            if (s_r.wstrb[0] && s_r.wdata[`CN_STAT_FLAG_BIT] && !(|cn_diff))
                            begin
                                s_nxt.cn_flag = 1'b0;
                            end
                        end
                        default:
                        begin
                            // unmapped: nothing stored
                        end
                    endcase
                    s_nxt.aw_got = 1'b0;
                    s_nxt.w_got = 1'b0;
                    s_nxt.rsp.bvalid = 1'b1;
                    s_nxt.rsp.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                    s_nxt.wr_st = WR_RESP;
                end
            end
            WR_RESP:
            begin
                if (axi_req.bready)
                begin
                    s_nxt.rsp.bvalid = 1'b0;
                    s_nxt.wr_st = WR_IDLE;
                end
            end
            default:
            begin
                s_nxt.wr_st = WR_IDLE;
            end
        endcase
        // ready while the holding slot is free and no answer is pending
        s_nxt.rsp.awready = !s_nxt.aw_got && (s_nxt.wr_st == WR_IDLE);
        s_nxt.rsp.wready = !s_nxt.w_got && (s_nxt.wr_st == WR_IDLE);

        case (s_r.rd_st)
            RD_IDLE:
            begin
                if (axi_req.arvalid)
                begin
                    s_nxt.rsp.rvalid = 1'b1;
                    s_nxt.rsp.rdata = rd_val;
                    s_nxt.rsp.rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
                    s_nxt.rsp.arready = 1'b0;
                    s_nxt.rd_st = RD_RESP;
                end
            end
            RD_RESP:
            begin
                if (axi_req.rready)
                begin
                    s_nxt.rsp.rvalid = 1'b0;
                    s_nxt.rsp.arready = 1'b1;
                    s_nxt.rd_st = RD_IDLE;
                end
            end
            default:
            begin
                s_nxt.rd_st = RD_IDLE;
            end
        endcase

        // pad drive from the new latch and direction values
        for (int p = 0; p < 3; p++)
        begin
            s_nxt.pin_out[p] = s_nxt.lat[p];
            s_nxt.pin_oe[p] = ~s_nxt.dir[p];
        end
        // pulls follow their registers; no interlock, software keeps them exclusive
        s_nxt.pu_out = s_nxt.pu;
        s_nxt.pd_out = s_nxt.pd;
    end

    // state register, synchronous active-low reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r <= '0;
            s_r.ans <= {3{`ANS_RESET}} & ANS_IMPL;
            s_r.dir <= {3{`DIR_RESET}};
            s_r.lat <= {3{`LAT_RESET}};
            s_r.pin_out <= {3{`LAT_RESET}};
            s_r.pin_oe <= '0;
            s_r.cn_en <= `CN_RESET;
            s_r.pu <= `CN_RESET;
            s_r.pd <= `CN_RESET;
            s_r.wr_st <= WR_IDLE;
            s_r.rd_st <= RD_IDLE;
            s_r.rsp.awready <= 1'b1;
            s_r.rsp.wready <= 1'b1;
            s_r.rsp.arready <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state flops
    assign axi_rsp = s_r.rsp;
    assign pin_out = s_r.pin_out;
    assign pin_oe = s_r.pin_oe;
    assign pullup_en = s_r.pu_out;
    assign pulldown_en = s_r.pd_out;
    assign change_irq = s_r.cn_flag;
    assign digital_in_off = s_r.ans;

endmodule

/* sim/port_ans_cn_chk.sv */
`timescale 1ns/1ps
module port_ans_cn_chk
    import port_ans_cn_pkg::*;
#(
    parameter int PIN_COUNT = 44
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire axi_req_s axi_req,
    input wire axi_rsp_s axi_rsp,
    input wire port3_t pin_in,
    input wire port3_t pin_out,
    input wire port3_t pin_oe,
    input wire logic [22:0] change_in,
    input wire logic sleep,
    input wire logic [22:0] pullup_en,
    input wire logic [22:0] pulldown_en,
    input wire logic change_irq,
    input wire port3_t digital_in_off
);
    // implemented select bits shrink on the small variants
    localparam logic [15:0] mask_b = (PIN_COUNT == 20) ? 16'hf017 : 16'hf01f;
    localparam logic [15:0] mask_c = (PIN_COUNT <= 28) ? 16'h0000 : 16'h0007;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // aw and w taken at one edge, then response two edges on
    sequence s_both;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_resp;
        !axi_rsp.bvalid ##1 axi_rsp.bvalid;
    endsequence
    AST_RST_SEL: assert property ($rose(aresetn) |-> digital_in_off[0] == 16'h000f &&
        digital_in_off[1] == mask_b && digital_in_off[2] == mask_c) else $error("select reset value wrong");
    AST_RST_DIR: assert property ($rose(aresetn) |-> pin_oe == '0 && !change_irq)
        else $error("pins not inputs after reset");
    AST_UNIMP: assert property (((digital_in_off[0] & ~16'h000f) | (digital_in_off[1] & ~mask_b)
        | (digital_in_off[2] & ~mask_c)) == 16'h0000) else $error("unimplemented select bit set");
    AST_RD_LAT: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer late");
    AST_WR_LAT: assert property (s_both |=> s_resp) else $error("write answer timing wrong");
    AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read data dropped");
    AST_OE_WR: assert property ($changed(pin_oe) |-> $past(axi_req.wvalid, 2))
        else $error("drive enable moved without write");
    AST_PULL_WR: assert property ($changed(pullup_en) || $changed(pulldown_en) |-> $past(axi_req.wvalid, 2))
        else $error("pull enable moved without write");
    AST_IRQ_SET: assert property ($rose(change_irq) && !$past(sleep, 2) |->
        $past(change_in) != $past(change_in, 2)) else $error("flag set with no input change");
    AST_IRQ_CLR: assert property ($fell(change_irq) |-> $past(axi_req.wvalid, 2) && $past(axi_req.wdata[0], 2))
        else $error("flag cleared without write");
endmodule

bind port_ans_cn port_ans_cn_chk #(.PIN_COUNT(PIN_COUNT)) chk_i (.aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .change_in(change_in), .sleep(sleep), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
    .change_irq(change_irq), .digital_in_off(digital_in_off));

/* sim/pin_pads.sv */
`timescale 1ns/1ps
module pin_pads
    import port_ans_cn_pkg::*;
(
    input wire logic aclk,
    input wire port3_t pin_out,
    input wire port3_t pin_oe,
    input wire port3_t ext,
    input wire logic [22:0] press,
    input wire logic [22:0] pu,
    input wire logic [22:0] pd,
    output port3_t pin_in,
    output logic [22:0] change_in
);
    // open inputs wander every cycle so a stale level never passes for real
    logic [22:0] flt;
    always @(posedge aclk)
        flt <= (flt === 23'h15_5555) ? 23'h2a_aaaa : 23'h15_5555;
    // driven pins read back the device's own level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
    // buttons short to ground; released pins follow the pull, both pulls fight low
    assign change_in = ~press & ((pu & ~pd) | (flt & ~pu & ~pd));
endmodule

/* sim/port_ans_cn_test.sv */
`timescale 1ns/1ps
`include "port_ans_cn_defs.svh"
module port_ans_cn_test
    import port_ans_cn_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    axi_req_s req = '0;
    axi_rsp_s rsp;
    port3_t pin_in, pin_out, pin_oe, dio;
    port3_t ext = '0; // pad levels from outside
    logic [22:0] press = '0; // buttons held down
    logic [22:0] cn, pu, pd;
    logic sleep = 1'b0;
    logic irq;
    int bad_count = 0;
    int cmp_count = 0;
    always #10 aclk = ~aclk;
    port_ans_cn #(.PIN_COUNT(44)) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .change_in(cn), .sleep(sleep),
        .pullup_en(pu), .pulldown_en(pd), .change_irq(irq), .digital_in_off(dio));
    pin_pads pads (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .press(press),
        .pu(pu), .pd(pd), .pin_in(pin_in), .change_in(cn));
    // compare and count, case equality so unknowns fail
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
        cmp_count++;
        if (s !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask
    // one write; aw and w released each at its own ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (rsp.awready)
                req.awvalid <= 1'b0;
            if (rsp.wready)
                req.wvalid <= 1'b0;
        end
        while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        chk("bresp", er, rsp.bresp);
    endtask
    // one read, data compared at the rvalid edge
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (rsp.arready)
                req.arvalid <= 1'b0;
        end
        while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        chk("rdata", e, rsp.rdata);
        chk("rresp", er, rsp.rresp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic t_reset;
        rc(`OFS_ANS_A, 32'h0000_000f);
        rc(`OFS_ANS_B, 32'h0000_f01f);
        rc(`OFS_ANS_C, 32'h0000_0007);
        rc(`OFS_DIR_B, 32'h0000_ffff);
        chk("pin_oe", 48'h0, pin_oe);
        $display("reset test done");
    endtask
    // all ones then all zeros through every select register
    task automatic t_ans;
        logic [7:0] a[3] = '{`OFS_ANS_A, `OFS_ANS_B, `OFS_ANS_C};
        logic [15:0] m[3] = '{16'h000f, 16'hf01f, 16'h0007};
        for (int i = 0; i < 3; i++)
        begin
            wr(a[i], 32'hffff_ffff);
            rc(a[i], {16'h0000, m[i]});
            chk("buffer_off", m[i], dio[i]);
            wr(a[i], 32'h0000_0000);
            rc(a[i], 32'h0000_0000);
            chk("buffer_off", 48'h0, dio[i]);
        end
        $display("select test done");
    endtask
    // low nibble driven, then selected for analog
    task automatic t_port;
        ext[0] <= 16'ha5a0;
        wr(`OFS_LAT_A, 32'h0000_0005);
        wr(`OFS_DIR_A, 32'h0000_fff0);
        chk("pin_oe", 48'h0000_0000_000f, pin_oe);
        rc(`OFS_PORT_A, 32'h0000_a5a5);
        wr(`OFS_ANS_A, 32'h0000_000f);
        rc(`OFS_PORT_A, 32'h0000_a5a0);
        chk("pin_out", 48'h0005, pin_out[0]);
        chk("pin_oe", 48'h000f, pin_oe[0]);
        // analog pins back to input before any measurement
        wr(`OFS_DIR_A, 32'h0000_ffff);
        chk("pin_oe", 48'h0, pin_oe);
        rc(`OFS_PORT_A, 32'h0000_a5a0);
        $display("port test done");
    endtask
    // pulls, enables, masked pin, clear, sleep and the top input
    task automatic t_change;
        wr(`OFS_PU_LO, 32'h0000_0003);
        wr(`OFS_PD_LO, 32'h0000_0004);
        wr(`OFS_PU_HI, 32'h0000_0040);
        chk("pullup", 48'h40_0003, pu);
        chk("pulldown", 48'h00_0004, pd);
        wr(`OFS_CN_EN_LO, 32'h0000_0001);
        wr(`OFS_CN_EN_HI, 32'h0000_0040);
        chk("irq", 48'h0, irq);
        press <= 23'h00_0002;
        idle(3);
        chk("irq", 48'h0, irq);
        press <= 23'h00_0003;
        idle(3);
        chk("irq", 48'h1, irq);
        wr(`OFS_CN_STAT, 32'h0000_0001);
        chk("irq", 48'h0, irq);
        sleep <= 1'b1;
        press <= 23'h40_0003;
        idle(3);
        chk("irq", 48'h1, irq);
        sleep <= 1'b0;
        idle(2);
        wr(`OFS_CN_STAT, 32'h0000_0001);
        chk("irq", 48'h0, irq);
        $display("change test done");
    endtask
    // unmapped and misaligned places refuse
    task automatic t_bad;
        wr(8'h4c, 32'h0000_0001, 2'b10);
        wr(8'h02, 32'h0000_0001, 2'b10);
        rc(8'h4c, 32'h0000_0000, 2'b10);
        $display("refusal test done");
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_ans;
        t_port;
        t_change;
        t_bad;
        close_out;
    end
    // a hang costs a mismatch; the run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge aclk);
        bad_count++;
        close_out;
    end
endmodule
